/* File: hw/mcl_pkg.sv */
// package: constants and types of the configure command loader
package mcl_pkg;

  // ------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_BASE     = 8'h04;
  localparam logic [7:0] REG_FIRST    = 8'h08;
  localparam logic [7:0] REG_STATUS   = 8'h0c;
  localparam logic [7:0] REG_IRQ_STAT = 8'h10;
  localparam logic [7:0] REG_IRQ_MASK = 8'h14;
  localparam logic [7:0] REG_SET_LO   = 8'h18;
  localparam logic [7:0] REG_SET_HI   = 8'h1c;

  // ------------------------------------------------------------
  // command block layout
  // ------------------------------------------------------------
  localparam logic [31:0] OFS_LINK     = 32'h0000_0004;
  localparam logic [31:0] OFS_PARAM    = 32'h0000_0008;
  localparam int          BIT_EL       = 31;
  localparam int          BIT_IRQ_REQ  = 29;
  localparam int          BIT_CMD_LO   = 16;
  localparam int          BIT_DONE     = 15;
  localparam int          BIT_OK       = 13;
  localparam logic [2:0]  CMD_CONFIG   = 3'h2;
  localparam logic [5:0]  CNT_MIN      = 6'h08;
  localparam logic [5:0]  CNT_MAX      = 6'h16;
  localparam logic [4:0]  PHY_BYTE     = 5'h08;
  localparam logic [4:0]  LOCAL_BYTES  = 5'h08;

  // ------------------------------------------------------------
  // interrupt bits and reset values
  // ------------------------------------------------------------
  localparam int          IRQ_DONE     = 0;
  localparam int          IRQ_NOT_ACT  = 1;
  localparam logic [63:0] SETTINGS_RST = 64'h0;
  localparam logic [1:0]  MASK_RST     = 2'h0;

  typedef enum logic [2:0] {
    ST_IDLE, ST_RD_HDR, ST_RD_PARM, ST_SEND, ST_WR_STAT, ST_RD_LINK
  } mcl_state_t;

  typedef struct packed {
    mcl_state_t  state;
    logic [31:0] base;
    logic [31:0] first;
    logic [31:0] blk_addr;
    logic [31:0] hdr;
    logic [31:0] word;
    logic [2:0]  widx;
    logic [1:0]  lane;
    logic [5:0]  bcnt;
    logic [63:0] settings;
    logic        phy_written;
    logic        phy_bit;
    logic        err;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_mask;
    logic        ahb_wr;
    logic [7:0]  ahb_addr;
    logic [31:0] hrdata;
    logic        mem_req;
    logic        mem_we;
    logic [31:0] mem_addr;
    logic [31:0] mem_wdata;
  } mcl_st_t;

endpackage

/* File: hw/mcl_loader.sv */
// module: configure command loader with ahb-lite registers and memory master port
// ------------------------------------------------------------
// What this block does
// - command code 010b in an action block selects the configure operation
// - 8 to 22 parameter bytes accepted; a smaller or larger count is flagged as error
// - bytes zero to seven are kept locally as command unit settings
// - bytes from the eighth onward are forwarded byte by byte to the csma/cd unit
// - bytes beyond the supplied count keep their default values
// - first generation: no frames until the phy select bit has been written
// - later generation: no frames until the phy select bit is written as 1
// - parameters start at offset 08h, four per word, lowest byte in low lane
// - completion flag set in the status word after the command finishes
// - success flag set only when the command ran without error
// - interrupt-request flag raises the command-done interrupt after completion
// - end-of-list flag sends the unit idle and raises the not-active interrupt
// ------------------------------------------------------------
module mcl_loader #(
  parameter bit LATER_GEN = 1'b0
) (
  input  wire logic        clk_sys,      // system clock
  input  wire logic        rst,          // synchronous reset, active high
  input  wire logic        hsel,         // ahb slave select
  input  wire logic [31:0] haddr,        // ahb address
  input  wire logic [1:0]  htrans,       // ahb transfer type
  input  wire logic        hwrite,       // ahb write
  input  wire logic [2:0]  hsize,        // ahb size
  input  wire logic [31:0] hwdata,       // ahb write data
  input  wire logic        hready,       // ahb bus ready
  output logic             hreadyout,    // ahb slave ready
  output logic             hresp,        // ahb response
  output logic [31:0]      hrdata,       // ahb read data
  output logic             mem_req,      // memory request, held until ack
  output logic             mem_we,       // memory write
  output logic [31:0]      mem_addr,     // memory byte address
  output logic [31:0]      mem_wdata,    // memory write data
  input  wire logic        mem_ack,      // memory acknowledge pulse
  input  wire logic [31:0] mem_rdata,    // memory read data, valid with ack
  output logic             fwd_valid,    // forwarded byte valid
  output logic [7:0]       fwd_data,     // forwarded byte
  input  wire logic        fwd_ready,    // csma/cd unit absorbs byte
  output logic [4:0]       fwd_index,    // parameter byte number of fwd_data
  output logic [63:0]      cu_settings,  // parameter bytes 0..7
  output logic             link_enable,  // frames may be sent and received
  output logic             unit_active,  // command unit busy
  output logic             irq           // level interrupt
);

  mcl_pkg::mcl_st_t st_reg;
  mcl_pkg::mcl_st_t st_next;

  logic [4:0]  byte_num;
  logic [7:0]  cur_byte;
  logic        addr_ok;
  logic        start;
  logic [1:0]  irq_set;
  logic [1:0]  irq_clr;
  logic [31:0] rd_mux;
  logic        ok_flag;

  assign byte_num  = {st_reg.widx, st_reg.lane};
  assign cur_byte  = st_reg.word[{st_reg.lane, 3'b000} +: 8];
  assign addr_ok   = hsel && htrans[1] && hready;
  // zero wait state slave: every transfer answers OKAY at once
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = st_reg.hrdata;
  assign mem_req   = st_reg.mem_req;
  assign mem_we    = st_reg.mem_we;
  assign mem_addr  = st_reg.mem_addr;
  assign mem_wdata = st_reg.mem_wdata;
  assign cu_settings = st_reg.settings;
  assign unit_active = st_reg.state != mcl_pkg::ST_IDLE;
  // forwarding only for bytes past the local ones and inside the count
  assign fwd_valid = st_reg.state == mcl_pkg::ST_SEND && byte_num >= mcl_pkg::LOCAL_BYTES
                     && {1'b0, byte_num} < st_reg.bcnt;
  assign fwd_data  = cur_byte;
  assign fwd_index = byte_num;
  // no usable default: frames wait for an explicit write of the select bit
  assign link_enable = st_reg.phy_written && (!LATER_GEN || st_reg.phy_bit);
  assign irq = |(st_reg.irq_stat & st_reg.irq_mask);
  assign ok_flag = !st_reg.err;
  assign start = st_reg.ahb_wr && st_reg.ahb_addr == mcl_pkg::REG_CTRL && hwdata[0]
                 && st_reg.state == mcl_pkg::ST_IDLE;

  // ------------------------------------------------------------
  // register read mux, sampled in the address phase
  // ------------------------------------------------------------
  always_comb
  begin
    case (haddr[7:0])
      mcl_pkg::REG_CTRL:     rd_mux = {31'h0, unit_active};
      mcl_pkg::REG_BASE:     rd_mux = st_reg.base;
      mcl_pkg::REG_FIRST:    rd_mux = st_reg.first;
      mcl_pkg::REG_STATUS:   rd_mux = {27'h0, link_enable, st_reg.phy_bit, st_reg.phy_written,
                                       st_reg.err, unit_active};
      mcl_pkg::REG_IRQ_STAT: rd_mux = {30'h0, st_reg.irq_stat};
      mcl_pkg::REG_IRQ_MASK: rd_mux = {30'h0, st_reg.irq_mask};
      mcl_pkg::REG_SET_LO:   rd_mux = st_reg.settings[31:0];
      mcl_pkg::REG_SET_HI:   rd_mux = st_reg.settings[63:32];
      default:               rd_mux = 32'h0;
    endcase
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb
  begin
    st_next = st_reg;
    irq_set = 2'h0;
    irq_clr = 2'h0;

    // bus slave
    st_next.ahb_wr = addr_ok && hwrite;
    if (addr_ok)
    begin
      st_next.ahb_addr = haddr[7:0];
    end
    if (addr_ok && !hwrite)
    begin
      st_next.hrdata = rd_mux;
    end
    if (st_reg.ahb_wr)
    begin
      case (st_reg.ahb_addr)
        mcl_pkg::REG_BASE:     st_next.base = hwdata;
        mcl_pkg::REG_FIRST:    st_next.first = hwdata;
        mcl_pkg::REG_IRQ_STAT: irq_clr = hwdata[1:0];
        mcl_pkg::REG_IRQ_MASK: st_next.irq_mask = hwdata[1:0];
        default:               st_next.base = st_reg.base;
      endcase
    end

    case (st_reg.state)
      mcl_pkg::ST_IDLE:
      begin
        if (start)
        begin
          st_next.blk_addr = st_reg.base + st_reg.first;
          st_next.mem_req  = 1'b1;
          st_next.mem_we   = 1'b0;
          st_next.mem_addr = st_reg.base + st_reg.first;
          st_next.state    = mcl_pkg::ST_RD_HDR;
        end
      end
      mcl_pkg::ST_RD_HDR:
      begin
        if (mem_ack)
        begin
          st_next.hdr  = mem_rdata;
          st_next.widx = 3'h0;
          st_next.lane = 2'h0;
          st_next.err  = 1'b0;
          if (mem_rdata[mcl_pkg::BIT_CMD_LO +: 3] == mcl_pkg::CMD_CONFIG)
          begin
            st_next.mem_addr = st_reg.blk_addr + mcl_pkg::OFS_PARAM;
            st_next.state    = mcl_pkg::ST_RD_PARM;
          end
          else
          begin
            // unknown command: completed with error, no parameters read
            st_next.err      = 1'b1;
            st_next.mem_we   = 1'b1;
            st_next.mem_wdata = {mem_rdata[31:16], 1'b1, mem_rdata[14], 1'b0,
                                 mem_rdata[12:0]};
            st_next.mem_addr = st_reg.blk_addr;
            st_next.state    = mcl_pkg::ST_WR_STAT;
          end
        end
      end
      mcl_pkg::ST_RD_PARM:
      begin
        if (mem_ack)
        begin
          st_next.word    = mem_rdata;
          st_next.lane    = 2'h0;
          st_next.mem_req = 1'b0;
          st_next.state   = mcl_pkg::ST_SEND;
          if (st_reg.widx == 3'h0)
          begin
            st_next.bcnt = mem_rdata[5:0];
            if (mem_rdata[5:0] < mcl_pkg::CNT_MIN || mem_rdata[5:0] > mcl_pkg::CNT_MAX)
            begin
              st_next.err       = 1'b1;
              st_next.mem_req   = 1'b1;
              st_next.mem_we    = 1'b1;
              st_next.mem_addr  = st_reg.blk_addr;
              st_next.mem_wdata = {st_reg.hdr[31:16], 1'b1, st_reg.hdr[14], 1'b0,
                                   st_reg.hdr[12:0]};
              st_next.state     = mcl_pkg::ST_WR_STAT;
            end
          end
        end
      end
      mcl_pkg::ST_SEND:
      begin
        if ({1'b0, byte_num} >= st_reg.bcnt)
        begin
          // every forwarded byte has been taken before the status goes out
          st_next.mem_req   = 1'b1;
          st_next.mem_we    = 1'b1;
          st_next.mem_addr  = st_reg.blk_addr;
          st_next.mem_wdata = {st_reg.hdr[31:16], 1'b1, st_reg.hdr[14], ok_flag,
                               st_reg.hdr[12:0]};
          st_next.state     = mcl_pkg::ST_WR_STAT;
        end
        else
        begin
          if (byte_num < mcl_pkg::LOCAL_BYTES)
          begin
            // only bytes inside the count are touched, the rest keep defaults
            st_next.settings[{byte_num[2:0], 3'b000} +: 8] = cur_byte;
          end
          if (byte_num == mcl_pkg::PHY_BYTE)
          begin
            st_next.phy_written = 1'b1;
            st_next.phy_bit     = cur_byte[0];
          end
          if (byte_num < mcl_pkg::LOCAL_BYTES || fwd_ready)
          begin
            st_next.lane = st_reg.lane + 2'h1;
            if (st_reg.lane == 2'h3)
            begin
              st_next.widx     = st_reg.widx + 3'h1;
              st_next.mem_req  = 1'b1;
              st_next.mem_we   = 1'b0;
              st_next.mem_addr = st_reg.blk_addr + mcl_pkg::OFS_PARAM
                                 + {27'h0, st_reg.widx + 3'h1, 2'b00};
              st_next.state    = mcl_pkg::ST_RD_PARM;
            end
          end
        end
      end
      mcl_pkg::ST_WR_STAT:
      begin
        if (mem_ack)
        begin
          st_next.mem_we = 1'b0;
          irq_set[mcl_pkg::IRQ_DONE] = st_reg.hdr[mcl_pkg::BIT_IRQ_REQ];
          if (st_reg.hdr[mcl_pkg::BIT_EL])
          begin
            st_next.mem_req = 1'b0;
            irq_set[mcl_pkg::IRQ_NOT_ACT] = 1'b1;
            st_next.state = mcl_pkg::ST_IDLE;
          end
          else
          begin
            st_next.mem_addr = st_reg.blk_addr + mcl_pkg::OFS_LINK;
            st_next.state    = mcl_pkg::ST_RD_LINK;
          end
        end
      end
      mcl_pkg::ST_RD_LINK:
      begin
        if (mem_ack)
        begin
          // link is relative to the unit base
          st_next.blk_addr = st_reg.base + mem_rdata;
          st_next.mem_addr = st_reg.base + mem_rdata;
          st_next.state    = mcl_pkg::ST_RD_HDR;
        end
      end
      default:
      begin
        st_next.state   = mcl_pkg::ST_IDLE;
        st_next.mem_req = 1'b0;
      end
    endcase

    // set wins over a write-one clear in the same cycle
    st_next.irq_stat = (st_reg.irq_stat & ~irq_clr) | irq_set;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      st_reg          <= '0;
      st_reg.state    <= mcl_pkg::ST_IDLE;
      st_reg.settings <= mcl_pkg::SETTINGS_RST;
      st_reg.irq_mask <= mcl_pkg::MASK_RST;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb_chk @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_stat_done;
    st_reg.state == mcl_pkg::ST_WR_STAT && mem_ack;
  endsequence

  property p_bad_code;
    st_reg.state == mcl_pkg::ST_RD_HDR && mem_ack
      && mem_rdata[mcl_pkg::BIT_CMD_LO +: 3] != mcl_pkg::CMD_CONFIG
      |=> st_reg.state == mcl_pkg::ST_WR_STAT && mem_we && !mem_wdata[mcl_pkg::BIT_OK];
  endproperty
  a_bad_code: assert property (p_bad_code) else $error("wrong command code not failed");

  property p_max_count;
    fwd_valid |-> {1'b0, fwd_index} < mcl_pkg::CNT_MAX;
  endproperty
  a_max_count: assert property (p_max_count) else $error("byte beyond 22 forwarded");

  property p_local_only;
    fwd_valid |-> fwd_index >= mcl_pkg::LOCAL_BYTES;
  endproperty
  a_local_only: assert property (p_local_only) else $error("local byte forwarded");

  property p_fwd_hold;
    fwd_valid && !fwd_ready |=> fwd_valid && $stable(fwd_data) && $stable(fwd_index);
  endproperty
  a_fwd_hold: assert property (p_fwd_hold) else $error("forwarded byte dropped");

  property p_phy_gate;
    $rose(link_enable)
      |-> $past(st_reg.state == mcl_pkg::ST_SEND && byte_num == mcl_pkg::PHY_BYTE);
  endproperty
  a_phy_gate: assert property (p_phy_gate) else $error("link enabled too early");

  property p_parm_addr;
    st_reg.state == mcl_pkg::ST_RD_PARM && mem_req
      |-> mem_addr == st_reg.blk_addr + mcl_pkg::OFS_PARAM + {27'h0, st_reg.widx, 2'b00};
  endproperty
  a_parm_addr: assert property (p_parm_addr) else $error("parameter word address wrong");

  property p_done_flag;
    st_reg.state == mcl_pkg::ST_WR_STAT && mem_req
      |-> mem_we && mem_wdata[mcl_pkg::BIT_DONE] && mem_addr == st_reg.blk_addr;
  endproperty
  a_done_flag: assert property (p_done_flag) else $error("completion flag not written");

  property p_ok_flag;
    st_reg.state == mcl_pkg::ST_WR_STAT && mem_req |-> mem_wdata[mcl_pkg::BIT_OK] == !st_reg.err;
  endproperty
  a_ok_flag: assert property (p_ok_flag) else $error("success flag wrong");

  property p_done_irq;
    s_stat_done ##0 st_reg.hdr[mcl_pkg::BIT_IRQ_REQ] |=> st_reg.irq_stat[mcl_pkg::IRQ_DONE];
  endproperty
  a_done_irq: assert property (p_done_irq) else $error("command-done interrupt missing");

  property p_end_list;
    s_stat_done ##0 st_reg.hdr[mcl_pkg::BIT_EL]
      |=> st_reg.state == mcl_pkg::ST_IDLE && st_reg.irq_stat[mcl_pkg::IRQ_NOT_ACT];
  endproperty
  a_end_list: assert property (p_end_list) else $error("end of list not honoured");

  property p_stat_last;
    st_reg.state == mcl_pkg::ST_SEND && st_next.state == mcl_pkg::ST_WR_STAT
      |-> !fwd_valid ##1 (mem_req && mem_we);
  endproperty
  a_stat_last: assert property (p_stat_last) else $error("status before forwarding ended");

endmodule

/* File: dv/mcl_mem_model.sv */
// host memory model: command blocks in system memory behind the loader's memory port
module mcl_mem_model (
  input  wire logic        clk_sys,    // system clock
  input  wire logic        rst,        // synchronous reset, active high
  input  wire logic        mem_req,    // request level from the loader
  input  wire logic        mem_we,     // 1 = status write
  input  wire logic [31:0] mem_addr,   // byte address
  input  wire logic [31:0] mem_wdata,  // status word
  output logic             mem_ack,    // one-cycle acknowledge
  output logic [31:0]      mem_rdata   // read data, valid with ack
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------
  // storage and answer timing
  // ------------------------------------------------------------
  logic [31:0] mem [64];
  logic [1:0]  wait_cnt;
  logic        slow;

  // every other request is answered late, so both short and long waits are seen
  always @(posedge clk_sys)
  begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;  // read data means nothing outside the ack cycle
    if (rst)
    begin
      wait_cnt <= 2'h0;
      slow <= 1'b0;
      mem_rdata <= 32'h0;
    end
    else if (mem_req && !mem_ack)
    begin
      if (wait_cnt == (slow ? 2'h3 : 2'h0))
      begin
        mem_ack <= 1'b1;
        wait_cnt <= 2'h0;
        slow <= ~slow;
        if (mem_we)
          mem[mem_addr[7:2]] <= mem_wdata;
        else
          mem_rdata <= mem[mem_addr[7:2]];
      end
      else
        wait_cnt <= wait_cnt + 2'h1;
    end
  end

  // the driver lays out one block: header with done/ok cleared, link, packed bytes
  task automatic put_block(input int a, input logic [31:0] hdr, input logic [31:0] link,
                           input logic [7:0] b [22], input int n);
    mem[a / 4] = hdr & 32'hffff_5fff;
    mem[a / 4 + 1] = link;
    for (int k = 0; k < 24; k++)
    begin
      if (k % 4 == 0)
        mem[a / 4 + 2 + k / 4] = 32'h0;
      if (k < n && k < 22)
        mem[a / 4 + 2 + k / 4][8 * (k % 4) +: 8] = b[k];
    end
  endtask
endmodule

/* File: dv/mac_configure_command_loader_bench.sv */
// testbench: configure command loader driven over ahb-lite with a memory model
module mac_configure_command_loader_bench;
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------
  // signals and instances
  // ------------------------------------------------------------
  logic        clk_sys = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, fwd_ready = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hreadyout, hresp, mem_req, mem_we, mem_ack, fwd_valid;
  logic        link_enable, unit_active, irq, link_later;
  logic [31:0] hrdata, mem_addr, mem_wdata, mem_rdata, rd;
  logic [7:0]  fwd_data;
  logic [4:0]  fwd_index;
  logic [63:0] cu_settings, keep, held;
  logic [7:0]  b [22];
  logic [12:0] fq [$];
  int          mismatches = 0, n_compared = 0, wr_seen = 0;

  always #25 clk_sys = ~clk_sys;

  mcl_loader #(.LATER_GEN(1'b0)) i_dut (
    .clk_sys, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .mem_req, .mem_we, .mem_addr,
    .mem_wdata, .mem_ack, .mem_rdata, .fwd_valid, .fwd_data, .fwd_ready, .fwd_index,
    .cu_settings, .link_enable, .unit_active, .irq
  );

  // later generation gating, seen on a twin that runs in lockstep with i_dut
  mcl_loader #(.LATER_GEN(1'b1)) i_later (
    .clk_sys, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout(), .hresp(), .hrdata(), .mem_req(), .mem_we(),
    .mem_addr(), .mem_wdata(), .mem_ack, .mem_rdata, .fwd_valid(), .fwd_data(), .fwd_ready,
    .fwd_index(), .cu_settings(), .link_enable(link_later), .unit_active(), .irq()
  );

  mcl_mem_model i_mem (
    .clk_sys, .rst, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata
  );

  // csma/cd side stalls every other cycle; bytes taken are logged in order
  always @(posedge clk_sys)
  begin
    fwd_ready <= ~fwd_ready & ~rst;
    if (fwd_valid === 1'b1 && fwd_ready === 1'b1)
      fq.push_back({fwd_index, fwd_data});
    if (mem_req === 1'b1 && mem_we === 1'b1)
      wr_seen = fq.size();
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic ahb(input logic we, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= we;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // odd seed keeps byte 8 bit0 at 1, the phy select the host must write
  task automatic fill(input int n, input logic [7:0] s);
    for (int k = 0; k < 22; k++)
      b[k] = 8'(k) * 8'h02 + s;
    b[0] = 8'(n);
    b[3] = 8'h00;
    keep = {b[7], b[6], b[5], b[4], b[3], b[2], b[1], b[0]};
  endtask

  task automatic run(input logic [31:0] first);
    int i;
    ahb(1'b1, mcl_pkg::REG_FIRST, first);
    ahb(1'b1, mcl_pkg::REG_CTRL, 32'h1);
    for (i = 0; i < 4000 && (i < 3 || unit_active !== 1'b0); i++)
      @(posedge clk_sys);
    chk(unit_active, 64'h0);
  endtask

  task automatic finish_test();
    $display("TB: compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    finish_test();
  end

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    chk(link_enable, 64'h0);
    chk(hresp, 64'h0);
    ahb(1'b0, mcl_pkg::REG_IRQ_MASK, 32'h0);
    chk(rd, 64'(mcl_pkg::MASK_RST));
    ahb(1'b1, 8'h20, 32'hffff_ffff);
    ahb(1'b0, 8'h20, 32'h0);
    chk(rd, 64'h0);
    ahb(1'b1, mcl_pkg::REG_BASE, 32'h0);
    // longest block, last in list, with completion interrupt
    fill(22, 8'h41);
    i_mem.put_block(0, 32'ha002_0000, 32'h0, b, 22);
    run(32'h0);
    chk(i_mem.mem[0], 64'ha002_a000);
    chk(cu_settings, keep);
    ahb(1'b0, mcl_pkg::REG_SET_LO, 32'h0);
    chk(rd, {32'h0, keep[31:0]});
    ahb(1'b0, mcl_pkg::REG_SET_HI, 32'h0);
    chk(rd, {32'h0, keep[63:32]});
    chk(fq.size(), 64'd14);
    for (int k = 8; k < 22; k++)
      chk(fq[k - 8], {5'(k), b[k]});
    chk(wr_seen, 64'd14);
    chk(link_enable, 64'h1);
    chk(link_later, 64'h1);
    ahb(1'b0, mcl_pkg::REG_STATUS, 32'h0);
    chk(rd, 64'h1c);
    ahb(1'b0, mcl_pkg::REG_IRQ_STAT, 32'h0);
    chk(rd, 64'h3);
    chk(irq, 64'h0);
    // masking and write-one-to-clear
    ahb(1'b1, mcl_pkg::REG_IRQ_MASK, 32'h3);
    @(posedge clk_sys);
    chk(irq, 64'h1);
    ahb(1'b1, mcl_pkg::REG_IRQ_STAT, 32'h1);
    ahb(1'b0, mcl_pkg::REG_IRQ_STAT, 32'h0);
    chk(rd, 64'h2);
    ahb(1'b1, mcl_pkg::REG_IRQ_MASK, 32'h1);
    @(posedge clk_sys);
    chk(irq, 64'h0);
    ahb(1'b1, mcl_pkg::REG_IRQ_STAT, 32'h2);
    ahb(1'b0, mcl_pkg::REG_IRQ_STAT, 32'h0);
    chk(rd, 64'h0);
    // shortest block chained to a non-configure block that ends the list
    fill(8, 8'h13);
    i_mem.put_block(64, 32'h0002_0000, 32'h80, b, 8);
    i_mem.put_block(128, 32'h8000_0000, 32'h0, b, 8);
    run(32'h40);
    chk(i_mem.mem[16], 64'h0002_a000);
    chk(i_mem.mem[32], 64'h8000_8000);
    chk(cu_settings, keep);
    chk(fq.size(), 64'd14);
    ahb(1'b0, mcl_pkg::REG_IRQ_STAT, 32'h0);
    chk(rd, 64'h2);
    held = keep;
    // byte counts just outside the legal range are refused
    for (int j = 0; j < 2; j++)
    begin
      fill(j ? 23 : 7, 8'h55);
      i_mem.put_block(0, 32'h8002_0000, 32'h0, b, j ? 23 : 7);
      run(32'h0);
      chk(i_mem.mem[0], 64'h8002_8000);
      chk(cu_settings, held);
      chk(fq.size(), 64'd14);
    end
    // one forwarded byte carrying the phy select written as zero
    fill(9, 8'h40);
    i_mem.put_block(0, 32'h8002_0000, 32'h0, b, 9);
    run(32'h0);
    chk(i_mem.mem[0], 64'h8002_a000);
    chk(cu_settings, keep);
    chk(fq.size(), 64'd15);
    chk(fq[14], {5'd8, 8'h50});
    chk(link_enable, 64'h1);
    chk(link_later, 64'h0);
    finish_test();
  end
endmodule
